/* File: pkg/bfp_cfg.svh */
// Fixed offsets, field positions, reset values and timing figures of the fault priority block.
// Included by bare name by every design file that needs them.
`ifndef BFP_CFG_SVH
`define BFP_CFG_SVH

`define BFP_CLK_PERIOD_NS   40
`define BFP_TICK_US         1000
`define BFP_TICK_CYC        ((`BFP_TICK_US * 1000) / `BFP_CLK_PERIOD_NS)
`define BFP_SC_DLY_US       300
`define BFP_SC_DLY_CYC      ((`BFP_SC_DLY_US * 1000) / `BFP_CLK_PERIOD_NS)
`define BFP_OCG_ON_TICKS    16'h0400
`define BFP_OCG_OFF_TICKS   16'h0010
`define BFP_ODC_ON_TICKS    16'h0080
`define BFP_ODC_OFF_TICKS   16'h0001
`define BFP_OCU_ON_TICKS    16'h0010
`define BFP_OCU_OFF_TICKS   16'h0001
`define BFP_EXC_ON_TICKS    16'h0010
`define BFP_EXC_OFF_TICKS   16'h0001

`define BFP_ADDR_CTRL       4'h0
`define BFP_ADDR_STATUS     4'h4
`define BFP_ADDR_MASK       4'h8
`define BFP_ADDR_STATE      4'hC

`define BFP_CTRL_FAST_BIT   0
`define BFP_EV_OCG          0
`define BFP_EV_ODC          1
`define BFP_EV_OCU          2
`define BFP_EV_SC           3
`define BFP_EV_EXC          4
`define BFP_ST_DIS_BIT      5
`define BFP_ST_CHG_BIT      6
`define BFP_ST_PVDD_BIT     7
`define BFP_ST_PVSS_BIT     8
`define BFP_ST_STBY_BIT     9

`define BFP_CTRL_RST        1'h0
`define BFP_EV_RST          5'h00
`define BFP_MASK_RST        5'h00

`endif

/* File: pkg/bfp_pkg.sv */
// Types shared by the fault priority block.
// Needs nothing from its surroundings.
package bfp_pkg;
   typedef enum logic [1:0] {
      BFP_OFF = 2'b01,
      BFP_ON  = 2'b10
   } bfp_det_e;
   typedef logic [15:0] bfp_cnt_t;
   typedef logic [4:0]  bfp_ev_t;
endpackage

/* File: pkg/bfp_det_if.sv */
// Signals between the core and one delayed detector.
// The core drives condition and hold, the detector answers with its state.
`timescale 1ns/10ps
interface bfp_det_if;
   logic cond;
   logic hold;
   logic det;
   modport core (output cond, output hold, input det);
   modport unit (input cond, input hold, output det);
endinterface

/* File: src/bfp_sync3.sv */
// Three-stage synchroniser for comparator and test pins.
// Assumes the inputs are asynchronous to core_clk_in.
`timescale 1ns/10ps
module bfp_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk_in,    // Core clock
   input  wire logic         rst_n_in,  // Synchronised reset, active low
   input  wire logic [W-1:0] async_in,  // Raw pins
   output logic      [W-1:0] sync_out   // Settled copy
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

   // A change is taken only once stages two and three agree
   always_comb begin
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= async_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule

/* File: src/bfp_det.sv */
// One delayed detector: state flips after the condition has differed for a set count.
// Assumes tick_in is a one-cycle enable; hold restarts the count but keeps the state.
`timescale 1ns/10ps
module bfp_det
   import bfp_pkg::*;
(
   input  wire logic     clk_in,     // Core clock
   input  wire logic     rst_n_in,   // Synchronised reset, active low
   input  wire logic     tick_in,    // Count enable
   input  wire bfp_cnt_t on_lim_in,  // Ticks to enter detection
   input  wire bfp_cnt_t off_lim_in, // Ticks to release
   bfp_det_if.unit       dif         // Condition, hold and state
);
   bfp_det_e state_q, state_d;
   bfp_cnt_t cnt_q, cnt_d;
   logic     differ;
   bfp_cnt_t lim;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      differ  = (state_q == BFP_ON) != dif.cond;
      lim     = (state_q == BFP_ON) ? off_lim_in : on_lim_in;
      // A condition that drops during the delay aborts it
      if (dif.hold || !differ) begin
         cnt_d = '0;
      end else if (cnt_q >= lim) begin
         cnt_d = '0;
         case (state_q)
            BFP_OFF: state_d = BFP_ON;
            BFP_ON:  state_d = BFP_OFF;
            default: state_d = BFP_OFF;
         endcase
      end else if (tick_in) begin
         cnt_d = cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= BFP_OFF;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign dif.det = (state_q == BFP_ON);
endmodule

/* File: src/bfp_core.sv */
// Fault priority and arbitration core of a two-cell battery protector.
// Assumes comparator results arrive asynchronously and software sits on a plain register port.
`timescale 1ns/10ps
`include "bfp_cfg.svh"

// How it works
// RL1 - Over-discharge delay restarts from zero while over-charge is pending.
// RL2 - Over-discharge delay runs again once over-charge is detected, if still low.
// RL3 - Over-discharge after over-charge: pull sense to supply, but no standby.
// RL4 - Over-discharge delay keeps running whatever over-current does.
// RL5 - Over-discharge seen first aborts the pending over-current delay.
// RL6 - Over-discharge after over-current: drop ground pull, pull to supply, standby.
// RL7 - Over-discharge first in the overlap: pull to supply and enter standby.
// RL8 - Short-circuit detector never held or suspended by the priority logic.
// RL9 - Excessive-charger detection held while discharge faults are active.
// RL10 - Excessive-charger delay counts only with discharge gate high.
// RL11 - Over-charge keeps running; over-charge seen first aborts over-current delay.
// RL12 - Test mode shortens counter delays; short-circuit delay stays as is.
// RL13 - Discharge gate low on any completed discharge fault, high otherwise.
module bfp_core
   import bfp_pkg::*;
#(
   parameter int TICK_CYC   = `BFP_TICK_CYC,
   parameter int SC_DLY_CYC = `BFP_SC_DLY_CYC
) (
   input  wire logic        core_clk_in,    // 25 MHz core clock
   input  wire logic        arst_n_in,      // Asynchronous reset, active low
   input  wire logic        test_pin_in,    // Test pin, high shortens delays
   input  wire logic        ovc_cmp_in,     // A cell above over-charge level
   input  wire logic        ovd_cmp_in,     // A cell below over-discharge level
   input  wire logic        ocur_cmp_in,    // Sense node above over-current level
   input  wire logic        short_cmp_in,   // Sense node above short-circuit level
   input  wire logic        exch_cmp_in,    // Sense node below excessive-charger level
   input  wire logic        rel_cmp_in,     // Sense node below standby release level
   input  wire logic [3:0]  reg_addr_in,    // Register byte address
   input  wire logic [31:0] reg_wdata_in,   // Write data
   input  wire logic        reg_wr_in,      // Write strobe
   input  wire logic        reg_rd_in,      // Read strobe
   output logic      [31:0] reg_rdata_out,  // Read data, cycle after strobe
   output logic             chg_gate_out,   // Charge switch gate, high enables
   output logic             dis_gate_out,   // Discharge switch gate, high enables
   output logic             pull_vdd_out,   // Sense node pulled to supply
   output logic             pull_vss_out,   // Sense node pulled to ground
   output logic             standby_out,    // Standby mode
   output logic             irq_out         // Level interrupt
);
   logic [1:0] rst_sync_q;
   logic       rst_n;

   logic [6:0] pins_s;
   logic       test_s, ovc_s, ovd_s, ocur_s, short_s, exch_s, rel_s;

   logic       fast;
   bfp_cnt_t   div_q, div_d;
   logic       tick;

   logic       odc_first_q, odc_first_d;
   logic       ocg_first_q, ocg_first_d;

   logic       dis_q, dis_d;
   logic       chg_q, chg_d;
   logic       pvdd_q, pvdd_d;
   logic       pvss_q, pvss_d;
   logic       stby_q, stby_d;

   logic       ctrl_fast_q, ctrl_fast_d;
   bfp_ev_t    status_q, status_d;
   bfp_ev_t    mask_q, mask_d;
   bfp_ev_t    det_prev_q, det_now, det_rise;
   logic [31:0] rdata_q, rdata_d;
   logic        irq_q, irq_d;

   bfp_det_if ocg_if ();
   bfp_det_if odc_if ();
   bfp_det_if ocu_if ();
   bfp_det_if sc_if ();
   bfp_det_if exc_if ();

   // Reset release through two flip-flops
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   bfp_sync3 #(
      .W (7)
   ) u_sync (
      .clk_in   (core_clk_in),
      .rst_n_in (rst_n),
      .async_in ({test_pin_in, ovc_cmp_in, ovd_cmp_in, ocur_cmp_in,
                  short_cmp_in, exch_cmp_in, rel_cmp_in}),
      .sync_out (pins_s)
   );
   assign {test_s, ovc_s, ovd_s, ocur_s, short_s, exch_s, rel_s} = pins_s;

   // Oscillator divider; test mode makes every cycle a tick
   assign fast = test_s | ctrl_fast_q;
   always_comb begin
      if (div_q >= 16'(TICK_CYC - 1)) begin
         div_d = '0;
      end else begin
         div_d = div_q + 16'h0001;
      end
   end
   assign tick = fast | (div_q == 16'h0000); // see RL12

   // Which condition came first in an overlap with over-current
   always_comb begin
      odc_first_d = ovd_s & (odc_first_q | ~ocur_s);
      ocg_first_d = ovc_s & (ocg_first_q | ~ocur_s);
   end

   // Over-charge is never held by the other detections
   assign ocg_if.cond = ovc_s; // see RL11
   assign ocg_if.hold = 1'b0;

   // In standby the cells are not watched until a charger pulls the node down
   assign odc_if.cond = ovd_s | (stby_q & ~rel_s); // see RL4
   assign odc_if.hold = ovc_s & ~ocg_if.det; // see RL1, RL2

   assign ocu_if.cond = ocur_s;
   assign ocu_if.hold = ~ocu_if.det & (odc_first_q | ocg_first_q); // see RL5, RL11

   assign sc_if.cond = short_s;
   assign sc_if.hold = 1'b0; // see RL8

   // Gate low also keeps the counter at zero until it is released
   assign exc_if.cond = exch_s;
   assign exc_if.hold = ~dis_q | odc_if.det | ocu_if.det | sc_if.det; // see RL9, RL10

   bfp_det u_ocg (
      .clk_in     (core_clk_in),
      .rst_n_in   (rst_n),
      .tick_in    (tick),
      .on_lim_in  (`BFP_OCG_ON_TICKS),
      .off_lim_in (`BFP_OCG_OFF_TICKS),
      .dif        (ocg_if)
   );

   bfp_det u_odc (
      .clk_in     (core_clk_in),
      .rst_n_in   (rst_n),
      .tick_in    (tick),
      .on_lim_in  (`BFP_ODC_ON_TICKS),
      .off_lim_in (`BFP_ODC_OFF_TICKS),
      .dif        (odc_if)
   );

   bfp_det u_ocu (
      .clk_in     (core_clk_in),
      .rst_n_in   (rst_n),
      .tick_in    (tick),
      .on_lim_in  (`BFP_OCU_ON_TICKS),
      .off_lim_in (`BFP_OCU_OFF_TICKS),
      .dif        (ocu_if)
   );

   // Fixed cycle delay, deliberately outside the tick and test path
   bfp_det u_sc (
      .clk_in     (core_clk_in),
      .rst_n_in   (rst_n),
      .tick_in    (1'b1), // see RL12
      .on_lim_in  (16'(SC_DLY_CYC)),
      .off_lim_in (`BFP_OCU_OFF_TICKS),
      .dif        (sc_if)
   );

   bfp_det u_exc (
      .clk_in     (core_clk_in),
      .rst_n_in   (rst_n),
      .tick_in    (tick),
      .on_lim_in  (`BFP_EXC_ON_TICKS),
      .off_lim_in (`BFP_EXC_OFF_TICKS),
      .dif        (exc_if)
   );

   // Switch gates and sense node paths
   always_comb begin
      dis_d  = ~(odc_if.det | ocu_if.det | sc_if.det); // see RL13
      chg_d  = ~(ocg_if.det | exc_if.det);
      pvdd_d = odc_if.det; // see RL3, RL6, RL7
      pvss_d = (ocu_if.det | sc_if.det) & ~odc_if.det; // see RL6
      stby_d = odc_if.det & ~ocg_if.det; // see RL3, RL7
   end

   // Register port and interrupt
   assign det_now  = {exc_if.det, sc_if.det, ocu_if.det, odc_if.det, ocg_if.det};
   assign det_rise = det_now & ~det_prev_q;

   always_comb begin
      ctrl_fast_d = ctrl_fast_q;
      mask_d      = mask_q;
      status_d    = status_q;
      rdata_d     = 32'h0000_0000;
      if (reg_wr_in) begin
         case (reg_addr_in)
            `BFP_ADDR_CTRL:   ctrl_fast_d = reg_wdata_in[`BFP_CTRL_FAST_BIT];
            `BFP_ADDR_STATUS: status_d = status_q & ~reg_wdata_in[4:0];
            `BFP_ADDR_MASK:   mask_d = reg_wdata_in[4:0];
            default:          ;
         endcase
      end
      // A new event outranks a clear in the same cycle
      status_d = status_d | det_rise;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `BFP_ADDR_CTRL:   rdata_d = {31'h0, ctrl_fast_q};
            `BFP_ADDR_STATUS: rdata_d = {27'h0, status_q};
            `BFP_ADDR_MASK:   rdata_d = {27'h0, mask_q};
            `BFP_ADDR_STATE:  rdata_d = {22'h0, stby_q, pvss_q, pvdd_q, chg_q, dis_q, det_now};
            default:          rdata_d = 32'h0000_0000;
         endcase
      end
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         div_q       <= '0;
         odc_first_q <= 1'b0;
         ocg_first_q <= 1'b0;
         dis_q       <= 1'b1;
         chg_q       <= 1'b1;
         pvdd_q      <= 1'b0;
         pvss_q      <= 1'b0;
         stby_q      <= 1'b0;
         ctrl_fast_q <= `BFP_CTRL_RST;
         status_q    <= `BFP_EV_RST;
         mask_q      <= `BFP_MASK_RST;
         det_prev_q  <= '0;
         rdata_q     <= 32'h0000_0000;
         irq_q       <= 1'b0;
      end else begin
         div_q       <= div_d;
         odc_first_q <= odc_first_d;
         ocg_first_q <= ocg_first_d;
         dis_q       <= dis_d;
         chg_q       <= chg_d;
         pvdd_q      <= pvdd_d;
         pvss_q      <= pvss_d;
         stby_q      <= stby_d;
         ctrl_fast_q <= ctrl_fast_d;
         status_q    <= status_d;
         mask_q      <= mask_d;
         det_prev_q  <= det_now;
         rdata_q     <= rdata_d;
         irq_q       <= irq_d;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign chg_gate_out  = chg_q;
   assign dis_gate_out  = dis_q;
   assign pull_vdd_out  = pvdd_q;
   assign pull_vss_out  = pvss_q;
   assign standby_out   = stby_q;
   assign irq_out       = irq_q;
endmodule

/* File: verification/bfp_core_chk_sva.sv */
// Port-level checker for the fault priority core.
// Bound to every bfp_core instance; sees only its ports.
`timescale 1ns/10ps
module bfp_core_chk #(
   parameter int SC_DLY_CYC = 5
) (
   input  wire logic        core_clk_in,    // Core clock
   input  wire logic        arst_n_in,      // Reset, active low
   input  wire logic        short_cmp_in,   // Short-circuit comparator
   input  wire logic        reg_rd_in,      // Read strobe
   input  wire logic [31:0] reg_rdata_out,  // Read data
   input  wire logic        chg_gate_out,   // Charge gate
   input  wire logic        dis_gate_out,   // Discharge gate
   input  wire logic        pull_vdd_out,   // Pull to supply
   input  wire logic        pull_vss_out,   // Pull to ground
   input  wire logic        standby_out     // Standby
);
   // Sync, count and output stage on top of the short delay
   localparam int SC_LIM = SC_DLY_CYC + 8;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   stby_dis_low_a: assert property (standby_out |-> !dis_gate_out)
      else $error("discharge gate high in standby");
   stby_pull_a: assert property (standby_out |-> pull_vdd_out && !pull_vss_out)
      else $error("standby without supply pull");
   pull_excl_a: assert property (!(pull_vdd_out && pull_vss_out))
      else $error("both pull paths selected");
   vss_dis_a: assert property (pull_vss_out |-> !dis_gate_out)
      else $error("ground pull with discharge gate high");
   vdd_dis_a: assert property (pull_vdd_out |-> !dis_gate_out)
      else $error("supply pull with discharge gate high");
   stby_chg_a: assert property (standby_out |-> chg_gate_out)
      else $error("standby while over-charge detected");
   short_trip_a: assert property (short_cmp_in [*8] |-> ##[0:SC_LIM] !dis_gate_out)
      else $error("short circuit did not open discharge gate");
   rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data outside read cycle");
endmodule

bind bfp_core bfp_core_chk #(.SC_DLY_CYC(SC_DLY_CYC)) bfp_core_chk_i (
   .core_clk_in   (core_clk_in),
   .arst_n_in     (arst_n_in),
   .short_cmp_in  (short_cmp_in),
   .reg_rd_in     (reg_rd_in),
   .reg_rdata_out (reg_rdata_out),
   .chg_gate_out  (chg_gate_out),
   .dis_gate_out  (dis_gate_out),
   .pull_vdd_out  (pull_vdd_out),
   .pull_vss_out  (pull_vss_out),
   .standby_out   (standby_out)
);

/* File: verification/bfp_pack_model.sv */
// Cells, charger and load reduced to comparator levels.
// Bench sets the condition vector; pins move just after a clock edge.
`timescale 1ns/10ps
module bfp_pack_model (
   input  wire logic       clk_in,   // Core clock
   input  wire logic [5:0] cond_in,  // {rel,exch,short,ocur,ovd,ovc}
   output logic      [5:0] cmp_out   // Comparator pins, same order
);
   initial cmp_out = 6'h00;
   always @(posedge clk_in) begin
      cmp_out <= cond_in;
   end
endmodule

/* File: verification/tb_battery_fault_priority_logic.sv */
// Self-checking bench for the fault priority core.
// Comparators come from the pack model; registers are reached directly.
`timescale 1ns/10ps
`include "bfp_cfg.svh"
module tb_battery_fault_priority_logic;
   typedef struct packed {logic [5:0] c; logic [11:0] w; logic [9:0] e;} bfp_tb_row_s;
   logic        clk;
   logic        arst_n;
   logic        test_pin;
   logic [5:0]  cond;
   logic [5:0]  cmp;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        chg;
   logic        dis;
   logic        vdd;
   logic        vss;
   logic        stby;
   logic        irq;
   logic [31:0] d;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cycles = 0;
   bfp_tb_row_s rows [0:24];

   bfp_pack_model bfp_pack_model_i (.clk_in(clk), .cond_in(cond), .cmp_out(cmp));
   bfp_core #(.TICK_CYC(4), .SC_DLY_CYC(5)) bfp_core_i (
      .core_clk_in(clk), .arst_n_in(arst_n), .test_pin_in(test_pin),
      .ovc_cmp_in(cmp[0]), .ovd_cmp_in(cmp[1]), .ocur_cmp_in(cmp[2]),
      .short_cmp_in(cmp[3]), .exch_cmp_in(cmp[4]), .rel_cmp_in(cmp[5]),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .chg_gate_out(chg), .dis_gate_out(dis),
      .pull_vdd_out(vdd), .pull_vss_out(vss), .standby_out(stby), .irq_out(irq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Whole run is about 3500 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      arst_n = 1'b0;
      test_pin = 1'b1;
      cond = 6'h00;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      // Condition, cycles to wait, expected state word
      rows = '{{6'h00, 12'h00A, 10'h060},
               {6'h04, 12'h01E, 10'h144},
               {6'h06, 12'h0A0, 10'h2C6},
               {6'h20, 12'h014, 10'h060},
               {6'h00, 12'h005, 10'h060},
               {6'h02, 12'h014, 10'h060},
               {6'h06, 12'h096, 10'h2C2},
               {6'h20, 12'h014, 10'h060},
               {6'h00, 12'h005, 10'h060},
               {6'h02, 12'h032, 10'h060},
               {6'h03, 12'h44C, 10'h021},
               {6'h03, 12'h0C8, 10'h083},
               {6'h20, 12'h028, 10'h060},
               {6'h01, 12'h014, 10'h060},
               {6'h05, 12'h44C, 10'h021},
               {6'h00, 12'h028, 10'h060},
               {6'h08, 12'h014, 10'h148},
               {6'h00, 12'h014, 10'h060},
               {6'h10, 12'h028, 10'h030},
               {6'h00, 12'h014, 10'h060},
               {6'h04, 12'h01E, 10'h144},
               {6'h14, 12'h028, 10'h144},
               {6'h10, 12'h00A, 10'h060},
               {6'h10, 12'h01E, 10'h030},
               {6'h00, 12'h014, 10'h060}};
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_rd(`BFP_ADDR_CTRL, d);
      check("ctrl reset", 32'h0, d);
      reg_rd(`BFP_ADDR_MASK, d);
      check("mask reset", 32'h0, d);
      reg_rd(`BFP_ADDR_STATUS, d);
      check("status reset", 32'h0, d);
      $display("reset values test done");
      for (int i = 0; i < 25; i++) begin
         @(posedge clk);
         cond <= rows[i].c;
         repeat (rows[i].w) @(posedge clk);
         reg_rd(`BFP_ADDR_STATE, d);
         check("state", {22'h0, rows[i].e}, d);
         check("pins", {27'h0, rows[i].e[9:5]}, {27'h0, stby, vss, vdd, chg, dis});
         $display("row %0d test done", i);
      end
      reg_rd(`BFP_ADDR_STATUS, d);
      check("status", 32'h1F, d);
      check("irq masked", 32'h0, {31'h0, irq});
      reg_wr(`BFP_ADDR_MASK, 32'h08);
      repeat (2) @(posedge clk);
      check("irq raised", 32'h1, {31'h0, irq});
      reg_wr(`BFP_ADDR_STATUS, 32'h08);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0, {31'h0, irq});
      reg_rd(`BFP_ADDR_STATUS, d);
      check("status w1c", 32'h17, d);
      reg_wr(4'h6, 32'h1F);
      reg_rd(`BFP_ADDR_MASK, d);
      check("mask after unmapped write", 32'h08, d);
      reg_rd(4'h2, d);
      check("unmapped read", 32'h0, d);
      $display("interrupt test done");
      @(posedge clk);
      cond <= 6'h04;
      repeat (30) @(posedge clk);
      check("dis before reset", 32'h0, {31'h0, dis});
      arst_n <= 1'b0;
      cond <= 6'h00;
      @(negedge clk);
      check("gates in reset", 32'h3, {30'h0, chg, dis});
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_rd(`BFP_ADDR_MASK, d);
      check("mask after reset", 32'h0, d);
      reg_rd(`BFP_ADDR_STATE, d);
      check("state after reset", 32'h060, d);
      $display("mid-run reset test done");
      // Slow ticks: over-current takes 16 ticks of 4 cycles, short stays at 5 cycles
      @(posedge clk);
      test_pin <= 1'b0;
      cond <= 6'h04;
      repeat (30) @(posedge clk);
      check("slow delay pending", 32'h1, {31'h0, dis});
      repeat (70) @(posedge clk);
      check("slow delay done", 32'h0, {31'h0, dis});
      cond <= 6'h08;
      repeat (12) @(posedge clk);
      reg_rd(`BFP_ADDR_STATE, d);
      check("slow short", 32'h148, d);
      @(posedge clk);
      cond <= 6'h00;
      repeat (10) @(posedge clk);
      reg_wr(`BFP_ADDR_CTRL, 32'h1);
      reg_rd(`BFP_ADDR_CTRL, d);
      check("ctrl fast", 32'h1, d);
      @(posedge clk);
      cond <= 6'h04;
      repeat (30) @(posedge clk);
      check("soft fast", 32'h0, {31'h0, dis});
      $display("slow mode test done");
      conclude();
   end
endmodule
